// ---- verilog/i2c_bit_level.sv ----
// bit-level two-wire serial interface: filter, conditions, stretch, flags, master clock
//
// What this block does
// - pins only pulled low or released
// - master and slave, transmit and receive
// - filter SDA and SCL before use
// - start request after START, next SCL fall
// - detect STOP, SDA rising while SCL high
// - latch SDA of each clock pulse
// - hold SCL low after bit until released
// - read-bit-done set when pulse ends
// - write-bit-done set unless arbitration lost
// - clock-rise flag on SCL low-to-high
// - busy set by START, cleared by STOP
// - resume releases SCL, clears three flags
// - master bit write generates SCL pulse
// - master makes START, STOP, arbitrates, clocks
// - three register groups of software control
`include "i2c_bit_consts.svh"
module i2c_bit_level
   import i2c_bit_pkg::*;
#(
   parameter int FILTER_TAPS = `FILTER_TAPS
) (
   input  wire logic ref_clk,
   input  wire logic link_clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic scl_in,
   output logic      scl_out,
   output logic      scl_oe_n,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_n,
   input  wire logic irq_wr,
   input  wire logic irq_wdata,
   input  wire logic sbit_wr,
   input  wire logic sbit_wdata,
   input  wire logic ctrl_wr,
   input  wire logic ctrl_transmit_bit,
   input  wire logic ctrl_scl_out,
   input  wire logic ctrl_clock_rise,
   input  wire logic ctrl_master,
   input  wire logic ctrl_enable,
   input  wire logic cmd_start,
   input  wire logic cmd_stop,
   output logic      received_bit,
   output logic      read_bit_done,
   output logic      write_bit_done,
   output logic      clock_rise_seen,
   output logic      bus_busy_flag,
   output logic      start_irq,
   output logic      scl_level,
   output logic      arb_lost,
   output logic      master_active
);
   // ==========================================
   // timing in ref_clk cycles, least times rounded up
   function automatic tick_t ns_cycles(input int ns);
      int c;
      c = (ns * `REF_CLK_KHZ + 999999) / 1000000;
      if (c < 1) begin
         c = 1;
      end
      return tick_t'(c);
   endfunction : ns_cycles

   localparam tick_t T_LOW_CYC   = ns_cycles(`T_LOW_NS);
   localparam tick_t T_HIGH_CYC  = ns_cycles(`T_HIGH_NS);
   localparam tick_t T_HD_STA_CYC = ns_cycles(`T_HD_STA_NS);
   localparam tick_t T_SU_STO_CYC = ns_cycles(`T_SU_STO_NS);

   // ==========================================
   // link domain: reset and enable cross in, pins are filtered there
   logic [1:0] link_ctl;
   logic       scl_filt;
   logic       sda_filt;

   i2c_bit_sync #(.WIDTH(2)) u_link_ctl (
      .clk (link_clk),
      .d   ({reset, clk_en}),
      .q   (link_ctl)
   );

   i2c_bit_filter #(.TAPS(FILTER_TAPS)) u_scl_filter (
      .clk     (link_clk),
      .rst     (link_ctl[1]),
      .en      (link_ctl[0]),
      .pin     (scl_in),
      .level_q (scl_filt)
   );

   i2c_bit_filter #(.TAPS(FILTER_TAPS)) u_sda_filter (
      .clk     (link_clk),
      .rst     (link_ctl[1]),
      .en      (link_ctl[0]),
      .pin     (sda_in),
      .level_q (sda_filt)
   );

   // ==========================================
   // filtered levels back into the ref_clk domain
   logic [1:0] lvl;
   logic       scl_prev_q;
   logic       sda_prev_q;

   i2c_bit_sync #(.WIDTH(2)) u_lvl_sync (
      .clk (ref_clk),
      .d   ({scl_filt, sda_filt}),
      .q   (lvl)
   );

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (clk_en) begin
         scl_prev_q <= lvl[1];
         sda_prev_q <= lvl[0];
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise  = lvl[1] & ~scl_prev_q;
   assign scl_fall  = ~lvl[1] & scl_prev_q;
   assign start_det = lvl[1] & scl_prev_q & sda_prev_q & ~lvl[0];
   assign stop_det  = lvl[1] & scl_prev_q & ~sda_prev_q & lvl[0];

   // ==========================================
   // software control bits
   logic enable_q;
   logic master_q;
   logic tx_bit_q;
   logic scl_sw_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         enable_q <= `RST_ENABLE;
         master_q <= `RST_MASTER;
         scl_sw_q <= `RST_SCL_OUT;
      end else if (clk_en && ctrl_wr) begin
         enable_q <= ctrl_enable;
         master_q <= ctrl_master;
         scl_sw_q <= ctrl_scl_out;
      end
   end

   // both the control group and the single-bit register load the transmit bit
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tx_bit_q <= `RST_TRANSMIT_BIT;
      end else if (clk_en) begin
         if (sbit_wr) begin
            tx_bit_q <= sbit_wdata;
         end else if (ctrl_wr) begin
            tx_bit_q <= ctrl_transmit_bit;
         end
      end
   end

   logic resume;
   assign resume = sbit_wr | (ctrl_wr & ~ctrl_clock_rise) | cmd_stop;

   // ==========================================
   // bus busy and start request
   logic start_pend_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bus_busy_flag <= 1'b0;
      end else if (clk_en) begin
         if (start_det) begin
            bus_busy_flag <= 1'b1;
         end else if (stop_det) begin
            bus_busy_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         start_pend_q <= 1'b0;
      end else if (clk_en) begin
         if (start_det) begin
            start_pend_q <= 1'b1;
         end else if (scl_fall || stop_det) begin
            start_pend_q <= 1'b0;
         end
      end
   end

   // set beats a clear in the same cycle; hardware never clears it
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         start_irq <= `RST_IRQ;
      end else if (clk_en) begin
         if (enable_q && start_pend_q && scl_fall) begin
            start_irq <= 1'b1;
         end else if (irq_wr && !irq_wdata) begin
            start_irq <= 1'b0;
         end
      end
   end

   // ==========================================
   // bit capture, arbitration and per-bit flags
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         received_bit <= 1'b0;
      end else if (clk_en && lvl[1] && enable_q) begin
         received_bit <= lvl[0];
      end
   end

   // cleared at each new pulse so one bit's loss does not spill over
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         arb_lost <= 1'b0;
      end else if (clk_en) begin
         if (enable_q && lvl[1] && tx_bit_q && !lvl[0] && !start_det) begin
            arb_lost <= 1'b1;
         end else if (scl_rise) begin
            arb_lost <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clock_rise_seen <= 1'b0;
      end else if (clk_en) begin
         if (enable_q && scl_rise) begin
            clock_rise_seen <= 1'b1;
         end else if (resume) begin
            clock_rise_seen <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         read_bit_done  <= 1'b0;
         write_bit_done <= 1'b0;
      end else if (clk_en) begin
         if (enable_q && scl_fall) begin
            read_bit_done  <= 1'b1;
            write_bit_done <= ~arb_lost;
         end else if (resume) begin
            read_bit_done  <= 1'b0;
            write_bit_done <= 1'b0;
         end
      end
   end

   // ==========================================
   // clock stretch: SCL held low from the end of each bit until resume
   logic stretch_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stretch_q <= 1'b0;
      end else if (clk_en) begin
         if (!enable_q) begin
            stretch_q <= 1'b0;
         end else if (scl_fall) begin
            stretch_q <= 1'b1;
         end else if (resume) begin
            stretch_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // master sequencer: START, STOP and one SCL pulse per bit
   master_state_e m_state_q;
   tick_t         m_cnt_q;
   logic          m_go;
   logic          m_cnt_done;
   assign m_go       = clk_en & enable_q & master_q;
   assign m_cnt_done = (m_cnt_q == 16'h0000);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         m_state_q <= M_IDLE;
      end else if (clk_en) begin
         if (!enable_q || !master_q) begin
            m_state_q <= M_IDLE;
         end else begin
            case (m_state_q)
               M_IDLE: begin
                  if (cmd_start && !bus_busy_flag) begin
                     m_state_q <= M_STA_SETUP;
                  end else if (cmd_stop) begin
                     m_state_q <= M_STOP;
                  end else if (sbit_wr) begin
                     m_state_q <= M_CLK_LOW;
                  end
               end
               M_STA_SETUP: begin
                  if (lvl[1] && lvl[0] && m_cnt_done) begin
                     m_state_q <= M_STA_HOLD;
                  end
               end
               M_STA_HOLD: begin
                  if (m_cnt_done) begin
                     m_state_q <= M_STA_END;
                  end
               end
               M_STA_END: begin
                  if (!lvl[1]) begin
                     m_state_q <= M_IDLE;
                  end
               end
               M_CLK_LOW: begin
                  if (m_cnt_done) begin
                     m_state_q <= M_CLK_HIGH;
                  end
               end
               M_CLK_HIGH: begin
                  // a slave holding SCL low keeps the count from starting
                  if (lvl[1] && m_cnt_done) begin
                     m_state_q <= M_CLK_END;
                  end
               end
               M_CLK_END: begin
                  if (!lvl[1]) begin
                     m_state_q <= M_IDLE;
                  end
               end
               M_STOP: begin
                  if (lvl[1] && m_cnt_done) begin
                     m_state_q <= M_IDLE;
                  end
               end
               default: begin
                  m_state_q <= M_IDLE;
               end
            endcase
         end
      end
   end

   // the count restarts on entry to each timed state and, in M_CLK_HIGH and M_STOP, waits while SCL is held
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         m_cnt_q <= 16'h0000;
      end else if (m_go) begin
         if (m_state_q == M_IDLE) begin
            m_cnt_q <= cmd_start ? T_HIGH_CYC : (cmd_stop ? T_LOW_CYC : T_LOW_CYC);
         end else if (m_state_q == M_STA_SETUP && m_cnt_done && lvl[1] && lvl[0]) begin
            m_cnt_q <= T_HD_STA_CYC;
         end else if (m_state_q == M_CLK_LOW && m_cnt_done) begin
            m_cnt_q <= T_HIGH_CYC;
         end else if (m_state_q == M_STOP && !lvl[1]) begin
            m_cnt_q <= T_SU_STO_CYC;
         end else if (m_state_q == M_CLK_HIGH && !lvl[1]) begin
            m_cnt_q <= T_HIGH_CYC;
         end else if (!m_cnt_done) begin
            m_cnt_q <= m_cnt_q - 16'h0001;
         end
      end
   end

   // ==========================================
   // pin drive: outputs are fixed low, only the enables move
   logic scl_low_d;
   logic sda_low_d;

   always_comb begin
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
      if (enable_q) begin
         scl_low_d = stretch_q | ~scl_sw_q;
         sda_low_d = ~tx_bit_q & ~arb_lost;
         case (m_state_q)
            M_STA_HOLD: begin
               sda_low_d = 1'b1;
            end
            M_STA_END: begin
               // SDA stays low until SCL is seen low, else this is a STOP
               sda_low_d = 1'b1;
               scl_low_d = 1'b1;
            end
            M_CLK_LOW: begin
               scl_low_d = 1'b1;
            end
            M_CLK_HIGH: begin
               scl_low_d = 1'b0;
            end
            M_CLK_END: begin
               scl_low_d = 1'b1;
            end
            M_STOP: begin
               sda_low_d = 1'b1;
               scl_low_d = 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
      end else if (clk_en) begin
         scl_oe_n <= ~scl_low_d;
         sda_oe_n <= ~sda_low_d;
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
      end
   end

   // ==========================================
   // status outputs
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scl_level     <= 1'b1;
         master_active <= 1'b0;
      end else if (clk_en) begin
         scl_level     <= lvl[1];
         master_active <= (m_state_q != M_IDLE);
      end
   end
endmodule : i2c_bit_level

// ---- pkg/i2c_bit_consts.svh ----
// constants of the bit-level two-wire interface: timing, reset values, filter
`ifndef I2C_BIT_CONSTS_SVH
`define I2C_BIT_CONSTS_SVH
// ==========================================
// clock rate and bus timing (ns)
`define REF_CLK_KHZ   25000
`define T_LOW_NS      4700
`define T_HIGH_NS     4000
`define T_HD_STA_NS   4000
`define T_SU_STO_NS   4000
// ==========================================
// input filter depth (link clock samples)
`define FILTER_TAPS   4
// ==========================================
// reset values of the software-visible bits
`define RST_TRANSMIT_BIT 1'b0
`define RST_SCL_OUT      1'b0
`define RST_ENABLE       1'b0
`define RST_MASTER       1'b0
`define RST_IRQ          1'b0
`endif

// ---- pkg/i2c_bit_pkg.sv ----
// types shared by the bit-level two-wire interface
package i2c_bit_pkg;
   // ==========================================
   // master sequencer states, one-hot
   typedef enum logic [7:0] {
      M_IDLE      = 8'b0000_0001,
      M_STA_SETUP = 8'b0000_0010,
      M_STA_HOLD  = 8'b0000_0100,
      M_STA_END   = 8'b0000_1000,
      M_CLK_LOW   = 8'b0001_0000,
      M_CLK_HIGH  = 8'b0010_0000,
      M_CLK_END   = 8'b0100_0000,
      M_STOP      = 8'b1000_0000
   } master_state_e;
   typedef logic [15:0] tick_t;
endpackage : i2c_bit_pkg

// ---- verilog/i2c_bit_sync.sv ----
// two-flop level synchroniser, WIDTH independent bits
module i2c_bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // ==========================================
   // first stage feeds only the second
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule : i2c_bit_sync

// ---- verilog/i2c_bit_filter.sv ----
// pin input filter on the link clock: two-flop sync then stability filter
`include "i2c_bit_consts.svh"
module i2c_bit_filter #(
   parameter int TAPS = `FILTER_TAPS
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic en,
   input  wire logic pin,
   output logic      level_q
);
   logic [1:0] sync_q;
   logic [7:0] cnt_q;

   // ==========================================
   // pin synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_q <= 2'h3;
      end else if (en) begin
         sync_q <= {sync_q[0], pin};
      end
   end

   // ==========================================
   // a new level must stand TAPS samples; spikes shorter than that vanish
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q   <= 8'h00;
         level_q <= 1'b1;
      end else if (en) begin
         if (sync_q[1] == level_q) begin
            cnt_q <= 8'h00;
         end else if (cnt_q >= 8'(TAPS - 1)) begin
            cnt_q   <= 8'h00;
            level_q <= sync_q[1];
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule : i2c_bit_filter

// ---- verification/i2c_bit_level_checker.sv ----
// port assertions of the bit-level two-wire interface
module i2c_bit_level_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic irq_wr,
   input wire logic irq_wdata,
   input wire logic sbit_wr,
   input wire logic ctrl_wr,
   input wire logic ctrl_clock_rise,
   input wire logic scl_out,
   input wire logic sda_out,
   input wire logic scl_oe_n,
   input wire logic read_bit_done,
   input wire logic write_bit_done,
   input wire logic clock_rise_seen,
   input wire logic bus_busy_flag,
   input wire logic start_irq,
   input wire logic scl_level,
   input wire logic arb_lost
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // helpers
   // the clear may land one or two edges after the write, so keep both
   logic clr1_q;
   logic clr2_q;
   always_ff @(posedge ref_clk) begin
      clr1_q <= irq_wr && !irq_wdata && clk_en;
      clr2_q <= clr1_q;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ==========================================
   // assertions
   pins_never_high_a: assert property (!scl_out && !sda_out)
      else $error("pin output driven high");
   start_request_a: assert property ($rose(start_irq) |-> bus_busy_flag && !scl_level)
      else $error("start request without start and clock fall");
   busy_stop_a: assert property ($fell(bus_busy_flag) |-> scl_level)
      else $error("busy cleared while clock low");
   rise_flag_a: assert property ($rose(clock_rise_seen) |-> scl_level)
      else $error("clock rise flag with clock low");
   read_done_a: assert property ($rose(read_bit_done) |-> !scl_level)
      else $error("read done before pulse ended");
   write_done_a: assert property ($rose(read_bit_done) |-> write_bit_done == !arb_lost)
      else $error("write done disagrees with arbitration");
   stretch_low_a: assert property ($rose(read_bit_done) |-> ##[0:3] !scl_oe_n)
      else $error("clock not held low after bit");
   resume_clear_a: assert property ((sbit_wr || (ctrl_wr && !ctrl_clock_rise)) && clk_en
      |-> ##2 !read_bit_done && !write_bit_done && !clock_rise_seen)
      else $error("resume left a flag set");
   irq_sticky_a: assert property ($fell(start_irq) |-> clr1_q || clr2_q)
      else $error("start request dropped without clear");
endmodule : i2c_bit_level_checker

bind i2c_bit_level i2c_bit_level_checker chk_i (.ref_clk, .reset, .clk_en, .irq_wr,
   .irq_wdata, .sbit_wr, .ctrl_wr, .ctrl_clock_rise, .scl_out, .sda_out, .scl_oe_n,
   .read_bit_done, .write_bit_done, .clock_rise_seen, .bus_busy_flag, .start_irq,
   .scl_level, .arb_lost);

// ---- verification/i2c_bus_party.sv ----
// model of another party on the two-wire bus, with the pull-ups
module i2c_bus_party (
   input  wire logic link_clk,
   input  wire logic scl_oe_n,
   input  wire logic sda_oe_n,
   output logic      scl_wire,
   output logic      sda_wire
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_pull = 1'b0;
   logic sda_pull = 1'b0;
   int   stalls   = 0;
   // ==========================================
   // wired-and with pull-ups: low while anyone pulls
   assign scl_wire = !(scl_pull || !scl_oe_n);
   assign sda_wire = !(sda_pull || !sda_oe_n);
   // ==========================================
   // bus actions, timed in link cycles
   task automatic hold(input int n);
      repeat (n) @(negedge link_clk);
   endtask : hold
   // a stretched clock may stay low; the bound keeps a hang finite
   task automatic wait_high();
      for (int n = 0; n < 300 && !scl_wire; n++) @(negedge link_clk);
      if (!scl_wire) stalls++;
   endtask : wait_high
   task automatic start_cond();
      sda_pull = 1'b1;
      hold(20);
      scl_pull = 1'b1;
      hold(20);
   endtask : start_cond
   // data only changes while the clock is low
   task automatic clock_bit(input logic b);
      sda_pull = !b;
      hold(10);
      scl_pull = 1'b0;
      wait_high();
      hold(20);
      scl_pull = 1'b1;
      hold(10);
   endtask : clock_bit
   task automatic stop_cond();
      sda_pull = 1'b1;
      hold(10);
      scl_pull = 1'b0;
      wait_high();
      hold(20);
      sda_pull = 1'b0;
      hold(20);
   endtask : stop_cond
   // shorter than the filter depth, so it must vanish
   task automatic glitch();
      sda_pull = 1'b1;
      hold(1);
      sda_pull = 1'b0;
      hold(20);
   endtask : glitch
endmodule : i2c_bus_party

// ---- verification/test_i2c_bit_level.sv ----
// testbench of the bit-level two-wire interface
module test_i2c_bit_level;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic irq_wr = 1'b0, irq_wdata = 1'b0, sbit_wr = 1'b0, sbit_wdata = 1'b0;
   logic ctrl_wr = 1'b0, ctrl_transmit_bit = 1'b0, ctrl_scl_out = 1'b0;
   logic ctrl_clock_rise = 1'b0, ctrl_master = 1'b0, ctrl_enable = 1'b0;
   logic cmd_start = 1'b0, cmd_stop = 1'b0;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_wire, sda_wire;
   logic received_bit, read_bit_done, write_bit_done, clock_rise_seen;
   logic bus_busy_flag, start_irq, scl_level, arb_lost, master_active;
   int   err_total = 0;
   int   num_checks = 0;
   logic [2:0] tt = 3'b011;
   logic [2:0] bb = 3'b001;
   // ==========================================
   // clocks, design and bus partner
   always #20 ref_clk = !ref_clk;
   initial begin
      #7;
      forever #32 link_clk = !link_clk;
   end
   i2c_bit_level #(.FILTER_TAPS(4)) dut (.ref_clk, .link_clk, .reset, .clk_en,
      .scl_in(scl_wire), .scl_out, .scl_oe_n, .sda_in(sda_wire), .sda_out, .sda_oe_n,
      .irq_wr, .irq_wdata, .sbit_wr, .sbit_wdata, .ctrl_wr, .ctrl_transmit_bit,
      .ctrl_scl_out, .ctrl_clock_rise, .ctrl_master, .ctrl_enable, .cmd_start, .cmd_stop,
      .received_bit, .read_bit_done, .write_bit_done, .clock_rise_seen, .bus_busy_flag,
      .start_irq, .scl_level, .arb_lost, .master_active);
   i2c_bus_party p (.link_clk, .scl_oe_n, .sda_oe_n, .scl_wire, .sda_wire);
   // ==========================================
   // access tasks
   task automatic chk(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : chk
   task automatic ctrl(input logic en, input logic mst, input logic rise);
      @(negedge ref_clk);
      {ctrl_wr, ctrl_enable, ctrl_master} = {1'b1, en, mst};
      {ctrl_transmit_bit, ctrl_scl_out, ctrl_clock_rise} = {2'b11, rise};
      @(negedge ref_clk);
      ctrl_wr = 1'b0;
   endtask : ctrl
   task automatic write_bit(input logic b);
      @(negedge ref_clk);
      {sbit_wr, sbit_wdata} = {1'b1, b};
      @(negedge ref_clk);
      sbit_wr = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask : write_bit
   task automatic clear_irq();
      @(negedge ref_clk);
      {irq_wr, irq_wdata} = 2'b10;
      @(negedge ref_clk);
      irq_wr = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask : clear_irq
   task automatic cmd(input logic sta);
      @(negedge ref_clk);
      {cmd_start, cmd_stop} = {sta, !sta};
      @(negedge ref_clk);
      {cmd_start, cmd_stop} = 2'b00;
   endtask : cmd
   function automatic logic flag(input int sel);
      case (sel)
         0: return read_bit_done;
         1: return bus_busy_flag;
         default: return start_irq;
      endcase
   endfunction : flag
   task automatic wait_for(input int sel, input logic val);
      int n;
      n = 0;
      while (flag(sel) !== val && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      if (flag(sel) !== val) begin
         chk("wait", val, flag(sel));
         test_done();
      end
   endtask : wait_for
   task automatic test_done();
      if (err_total == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // ==========================================
   // sequence
   initial begin
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      repeat (10) @(negedge ref_clk);
      chk("scl_oe_n", 1'b1, scl_oe_n);
      chk("sda_oe_n", 1'b1, sda_oe_n);
      chk("scl_level", 1'b1, scl_level);
      ctrl(1'b1, 1'b0, 1'b1);
      p.start_cond();
      wait_for(0, 1'b1);
      wait_for(2, 1'b1);
      chk("busy", 1'b1, bus_busy_flag);
      chk("scl_oe_n", 1'b0, scl_oe_n);
      repeat (50) @(negedge ref_clk);
      chk("start_irq", 1'b1, start_irq);
      clear_irq();
      chk("start_irq", 1'b0, start_irq);
      // released-one against a low bus is the arbitration case
      for (int i = 0; i < 3; i++) begin
         write_bit(tt[i]);
         chk("read_bit_done", 1'b0, read_bit_done);
         chk("clock_rise_seen", 1'b0, clock_rise_seen);
         chk("scl_oe_n", 1'b1, scl_oe_n);
         p.clock_bit(bb[i]);
         wait_for(0, 1'b1);
         chk("clock_rise_seen", 1'b1, clock_rise_seen);
         chk("received_bit", bb[i] & tt[i], received_bit);
         chk("write_bit_done", !(tt[i] & !bb[i]), write_bit_done);
         chk("arb_lost", tt[i] & !bb[i], arb_lost);
      end
      // a control write with the rise bit at zero is another resume path
      ctrl(1'b1, 1'b0, 1'b0);
      chk("read_bit_done", 1'b0, read_bit_done);
      chk("write_bit_done", 1'b0, write_bit_done);
      p.stop_cond();
      wait_for(1, 1'b0);
      chk("busy", 1'b0, bus_busy_flag);
      p.glitch();
      repeat (20) @(negedge ref_clk);
      chk("busy", 1'b0, bus_busy_flag);
      chk("start_irq", 1'b0, start_irq);
      ctrl(1'b1, 1'b1, 1'b1);
      cmd(1'b1);
      repeat (2) @(negedge ref_clk);
      chk("master_active", 1'b1, master_active);
      wait_for(2, 1'b1);
      chk("busy", 1'b1, bus_busy_flag);
      clear_irq();
      write_bit(1'b1);
      wait_for(0, 1'b1);
      // the sequencer state reaches its status output one edge after the fall
      repeat (2) @(negedge ref_clk);
      chk("clock_rise_seen", 1'b1, clock_rise_seen);
      chk("write_bit_done", 1'b1, write_bit_done);
      chk("received_bit", 1'b1, received_bit);
      chk("master_active", 1'b0, master_active);
      cmd(1'b0);
      wait_for(1, 1'b0);
      chk("busy", 1'b0, bus_busy_flag);
      chk("bus stall", 1'b0, p.stalls != 0);
      test_done();
   end
endmodule : test_i2c_bit_level
